// *** rtl/period_div.sv ***
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module period_div #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_num,
  input  wire logic [W-1:0] i_den,
  output logic [W-1:0]      o_quo,
  output logic              o_busy
);
  if (W < 2) begin : g_chk
    $error("divider needs at least two bits");
  end
  logic [W-1:0]         quo_q;
  logic [W-1:0]         rem_q;
  logic [W-1:0]         den_q;
  logic [$clog2(W+1)-1:0] cnt_q;
  logic                 busy_q;
  wire  [W:0]           trial = {rem_q, quo_q[W-1]};
  wire                  fits  = trial >= {1'b0, den_q};
  wire  [W:0]           diff  = trial - {1'b0, den_q};

  // a zero divisor always fits, so it yields all ones
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      quo_q  <= '0;
      rem_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (i_start) begin
      quo_q  <= i_num;
      rem_q  <= '0;
      den_q  <= i_den;
      cnt_q  <= ($clog2(W+1))'(W);
      busy_q <= 1'b1;
    end else if (busy_q) begin
      rem_q  <= fits ? diff[W-1:0] : trial[W-1:0];
      quo_q  <= {quo_q[W-2:0], fits};
      cnt_q  <= cnt_q - 1'b1;
      busy_q <= (cnt_q != 1);
    end
  end
  assign o_quo  = quo_q;
  assign o_busy = busy_q;
endmodule
`default_nettype wire

// *** rtl/sync2_cdc.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync2_cdc #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic [W-1:0]      o_q
);
  if (W < 1) begin : g_chk
    $error("synchroniser needs at least one bit");
  end
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end
  assign o_q = sync_q;
endmodule
`default_nettype wire

// *** rtl/sync_clock_source_select.sv ***
// switching clock source selection with sync pin detect, drive and AXI4-Lite registers
// Functional notes
// - sync disabled: run on internal oscillator, ignore the sync pin entirely.
// - auto mode: detect a clock at each enable and lock to it if present.
// - auto mode: free-run when no clock at enable or when it is lost later.
// - input mode: check pin at every enable, then lock with no free-run fallback.
// - input mode without incoming clock: never switch, output never ramps.
// - output mode: run from oscillator and drive its waveform onto the sync pin.
// - output mode driver selectable between push-pull and open-drain.
// - output mode: the sync pin is not monitored for an incoming clock.
// - frequency readback may differ slightly from the written value (quantized).
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`include "sync_sel_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sync_clock_source_select
  import sync_sel_pkg::*;
#(
  parameter logic [15:0] OSC_KHZ   = `OSC_KHZ,
  parameter logic [15:0] WIN_CYC   = `DET_WIN_CYC,
  parameter logic [7:0]  MIN_EDGES = `DET_MIN_EDGES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [31:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_osc_clk,
  input  wire logic        i_sync_in,
  output logic             o_sync_out,
  output logic             o_sync_oe,
  output logic             o_sw_clk,
  output logic             o_sw_tick,
  output logic             o_switching
);
  if (WIN_CYC < 16'h0020 || MIN_EDGES == 8'h00) begin : g_chk
    $error("detect window must exceed divider latency and need at least one edge");
  end

  // register index: 0 none, 1 control, 2 frequency, 3 status
  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'b00};
    if (w == `REG_CTRL) reg_sel = 2'h1;
    else if (w == `REG_FREQ) reg_sel = 2'h2;
    else if (w == `REG_STAT) reg_sel = 2'h3;
    else reg_sel = 2'h0;
  endfunction

  // ---------------- bus domain ----------------
  logic        aw_got_q;
  logic        w_got_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        en_q;
  sync_mode_t  mode_q;
  logic        od_q;
  logic [15:0] freq_q;
  sel_stat_t   stat_s;
  localparam logic [3:0] RST_CTRL = `CTRL_RST;

  wire       aw_hs  = i_awvalid && o_awready;
  wire       w_hs   = i_wvalid && o_wready;
  wire       do_wr  = aw_got_q && w_got_q && !bvalid_q;
  wire [1:0] wr_sel = reg_sel(awaddr_q);
  wire [1:0] rd_sel = reg_sel(i_araddr);
  wire       ar_hs  = i_arvalid && o_arready;
  wire       wr_ctl = do_wr && wr_sel == 2'h1 && wstrb_q[0];
  wire       wr_frq = do_wr && wr_sel == 2'h2;
  wire [15:0] frq_new = {wstrb_q[1] ? wdata_q[15:8] : freq_q[15:8],
                         wstrb_q[0] ? wdata_q[7:0] : freq_q[7:0]};

  // address and data are taken in either order; response after both
  assign o_awready = !aw_got_q && !bvalid_q;
  assign o_wready  = !w_got_q && !bvalid_q;
  assign o_arready = !rvalid_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

  // write channel capture and response
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // configuration registers; the status register is read only
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      en_q   <= RST_CTRL[`CTRL_EN_BIT];
      mode_q <= sync_mode_t'(RST_CTRL[`CTRL_MODE_LSB +: 2]);
      od_q   <= RST_CTRL[`CTRL_OD_BIT];
      freq_q <= `FREQ_RST & `FREQ_QMASK;
    end else begin
      if (wr_ctl) begin
        en_q   <= wdata_q[`CTRL_EN_BIT];
        mode_q <= sync_mode_t'(wdata_q[`CTRL_MODE_LSB +: 2]);
        od_q   <= wdata_q[`CTRL_OD_BIT];
      end
      if (wr_frq) begin
        freq_q <= frq_new & `FREQ_QMASK; // drop step bits
      end
    end
  end

  // read channel, one cycle to rvalid
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_sel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      case (rd_sel)
        2'h1:    rdata_q <= {28'h0, od_q, mode_q, en_q};
        2'h2:    rdata_q <= {16'h0, freq_q}; // quantized value
        2'h3:    rdata_q <= {28'h0, stat_s};
        default: rdata_q <= '0;
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- oscillator domain ----------------
  logic       orst_meta_q;
  logic       orst_q;
  sel_cfg_t   cfg_s;
  sel_cfg_t   cur_q;
  sel_state_t state_q;
  sel_state_t state_d;
  logic       en_prev_q;
  logic       sp_s;
  logic       sp_prev_q;
  logic [15:0] win_q;
  logic [7:0] edges_q;
  logic       present_q;
  logic       want_q;
  logic       locked_q;
  logic [15:0] period_q;
  logic [16:0] per_cnt_q;
  logic       run_q;
  logic       clk_q;
  logic       tick_q;
  logic       drive_q;
  logic       div_start_q;
  logic [15:0] quo;
  logic       div_busy;

  // reset release resynchronised to the oscillator
  always_ff @(posedge i_osc_clk or posedge i_reset) begin
    if (i_reset) begin
      orst_meta_q <= 1'b1;
      orst_q      <= 1'b1;
    end else begin
      orst_meta_q <= 1'b0;
      orst_q      <= orst_meta_q;
    end
  end

  // config is static while enabled, so bitwise sync is safe here
  sync2_cdc #(.W($bits(sel_cfg_t))) u_cfg_sync (
    .i_clk (i_osc_clk),
    .i_rst (orst_q),
    .i_d   ({en_q, mode_q, od_q, freq_q}),
    .o_q   (cfg_s)
  );
  sync2_cdc #(.W(1)) u_pin_sync (
    .i_clk (i_osc_clk),
    .i_rst (orst_q),
    .i_d   (i_sync_in),
    .o_q   (sp_s)
  );
  sync2_cdc #(.W($bits(sel_stat_t))) u_stat_sync (
    .i_clk (i_ref_clk),
    .i_rst (i_reset),
    .i_d   ({run_q, locked_q, present_q, state_q != ST_IDLE}),
    .o_q   (stat_s)
  );
  period_div #(.W(16)) u_div (
    .i_clk   (i_osc_clk),
    .i_rst   (orst_q),
    .i_start (div_start_q),
    .i_num   (OSC_KHZ),
    .i_den   (cur_q.freq),
    .o_quo   (quo),
    .o_busy  (div_busy)
  );

  wire monitor  = (cur_q.mode == MODE_AUTO || cur_q.mode == MODE_INPUT)
                  && state_q != ST_IDLE;
  wire rise     = monitor && sp_s && !sp_prev_q;
  wire win_end  = win_q == WIN_CYC - 16'h0001;
  wire edge_ok  = edges_q >= MIN_EDGES;
  wire start    = cfg_s.en && en_prev_q && state_q == ST_IDLE;
  wire in_run   = state_q == ST_RUN;
  // locked, a missing edge gives way at twice the period so loss is seen
  wire boundary = in_run && (locked_q ? (rise || per_cnt_q >= {period_q, 1'b0})
                                      : per_cnt_q >= {1'b0, period_q} - 17'h1);

  // source selection sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (start) state_d = ST_DETECT;
      ST_DETECT: begin
        if (!cfg_s.en) state_d = ST_IDLE;
        else if (win_end && !div_busy)
          state_d = (cur_q.mode == MODE_INPUT && !edge_ok) ? ST_HOLD : ST_RUN;
      end
      ST_RUN: begin
        if (!cfg_s.en) state_d = ST_IDLE;
        else if (win_end && cur_q.mode == MODE_INPUT && !edge_ok) state_d = ST_HOLD;
      end
      ST_HOLD:   if (!cfg_s.en) state_d = ST_IDLE; // no free-run
      default:   state_d = ST_IDLE;
    endcase
  end

  // state, capture of config at enable, divider launch
  always_ff @(posedge i_osc_clk or posedge orst_q) begin
    if (orst_q) begin
      state_q     <= ST_IDLE;
      cur_q       <= '0;
      en_prev_q   <= 1'b0;
      div_start_q <= 1'b0;
      sp_prev_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      en_prev_q   <= cfg_s.en;
      sp_prev_q   <= sp_s;
      div_start_q <= start;
      if (start) cur_q <= cfg_s; // detection restarts at each enable
    end
  end

  // edge counting over a fixed window of oscillator cycles
  always_ff @(posedge i_osc_clk or posedge orst_q) begin
    if (orst_q) begin
      win_q     <= '0;
      edges_q   <= '0;
      present_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      win_q     <= '0;
      edges_q   <= '0;
      present_q <= 1'b0;
    end else begin
      win_q   <= win_end ? 16'h0000 : win_q + 16'h0001;
      edges_q <= win_end ? 8'h00 : edges_q + {7'h0, rise && edges_q != 8'hff};
      if (win_end) present_q <= edge_ok;
    end
  end

  // lock wish follows each window; while staying in run the source changes only at a boundary
  always_ff @(posedge i_osc_clk or posedge orst_q) begin
    if (orst_q) begin
      want_q   <= 1'b0;
      locked_q <= 1'b0;
    end else if (state_d != ST_RUN) begin // leaving run drops the lock at once
      want_q   <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      if (win_end) want_q <= monitor && edge_ok;
      if (boundary) locked_q <= want_q;
    end
  end

  // period counter and switching outputs
  always_ff @(posedge i_osc_clk or posedge orst_q) begin
    if (orst_q) begin
      period_q  <= 16'h0002;
      per_cnt_q <= '0;
      run_q     <= 1'b0;
      clk_q     <= 1'b0;
      tick_q    <= 1'b0;
      drive_q   <= 1'b0;
    end else begin
      if (state_q == ST_DETECT && !div_busy && !div_start_q)
        period_q <= (quo < 16'h0002) ? 16'h0002 : quo;
      per_cnt_q <= (!in_run || boundary) ? 17'h0 : per_cnt_q + 17'h1;
      run_q     <= state_d == ST_RUN; // no switching outside run
      clk_q     <= in_run && state_d == ST_RUN && !boundary && per_cnt_q < {2'b0, period_q[15:1]};
      tick_q    <= boundary;
      drive_q   <= state_d == ST_RUN && cur_q.mode == MODE_OUTPUT;
    end
  end

  assign o_sw_clk    = clk_q;
  assign o_sw_tick   = tick_q;
  assign o_switching = run_q;
  // open drain pulls low only; push-pull drives both levels
  assign o_sync_out  = cur_q.od ? 1'b0 : clk_q;
  assign o_sync_oe   = drive_q && (cur_q.od ? !clk_q : 1'b1);

  // ---------------- checks ----------------
  property p_disabled_free;
    @(posedge i_osc_clk) disable iff (orst_q)
      cur_q.mode == MODE_DISABLED |-> !locked_q && edges_q == 8'h00 && !o_sync_oe;
  endproperty
  a_disabled_free: assert property (p_disabled_free) else $error("disabled mode used pin");

  property p_auto_lock;
    @(posedge i_osc_clk) disable iff (orst_q)
      in_run && cur_q.mode == MODE_AUTO && want_q && boundary && state_d == ST_RUN |=> locked_q;
  endproperty
  a_auto_lock: assert property (p_auto_lock) else $error("auto mode did not lock");

  property p_auto_fallback;
    @(posedge i_osc_clk) disable iff (orst_q)
      in_run && cur_q.mode == MODE_AUTO && boundary && !want_q && state_d == ST_RUN |=> !locked_q && o_switching;
  endproperty
  a_auto_fallback: assert property (p_auto_fallback) else $error("auto mode did not free-run");

  sequence s_input_miss;
    state_q == ST_DETECT && cur_q.mode == MODE_INPUT && win_end && !div_busy && !edge_ok && cfg_s.en;
  endsequence
  property p_input_hold;
    @(posedge i_osc_clk) disable iff (orst_q)
      s_input_miss |=> state_q == ST_HOLD ##1 !o_switching;
  endproperty
  a_input_hold: assert property (p_input_hold) else $error("input mode ran without clock");

  property p_hold_quiet;
    @(posedge i_osc_clk) disable iff (orst_q)
      state_q == ST_HOLD |-> !o_switching && !o_sw_clk && !locked_q;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("switching while held");

  property p_output_drive;
    @(posedge i_osc_clk) disable iff (orst_q)
      in_run && state_d == ST_RUN && cur_q.mode == MODE_OUTPUT |=> drive_q && !locked_q;
  endproperty
  a_output_drive: assert property (p_output_drive) else $error("output mode not driving");

  property p_od_drive;
    @(posedge i_osc_clk) disable iff (orst_q)
      drive_q && cur_q.od |-> !o_sync_out && (o_sync_oe == !o_sw_clk);
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open drain drove high");

  property p_output_blind;
    @(posedge i_osc_clk) disable iff (orst_q)
      cur_q.mode == MODE_OUTPUT |-> edges_q == 8'h00 && !present_q;
  endproperty
  a_output_blind: assert property (p_output_blind) else $error("output mode watched pin");

  property p_switch_at_boundary;
    @(posedge i_osc_clk) disable iff (orst_q)
      in_run && $past(in_run) && $changed(locked_q) |-> $past(boundary);
  endproperty
  a_switch_at_boundary: assert property (p_switch_at_boundary) else $error("source moved mid-period");

  property p_freq_quant;
    @(posedge i_ref_clk) disable iff (i_reset)
      wr_frq |=> freq_q == (frq_new & `FREQ_QMASK) ##1 (freq_q & ~`FREQ_QMASK) == 16'h0000;
  endproperty
  a_freq_quant: assert property (p_freq_quant) else $error("frequency not quantized");
endmodule
`default_nettype wire

// *** rtl/sync_sel_pkg.sv ***
// types shared by the clock source select block
package sync_sel_pkg;
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_AUTO     = 2'h1,
    MODE_INPUT    = 2'h2,
    MODE_OUTPUT   = 2'h3
  } sync_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_DETECT = 2'h1,
    ST_RUN    = 2'h3,
    ST_HOLD   = 2'h2
  } sel_state_t;
  typedef struct packed {
    logic       en;
    sync_mode_t mode;
    logic       od;
    logic [15:0] freq;
  } sel_cfg_t;
  typedef struct packed {
    logic run;
    logic locked;
    logic present;
    logic active;
  } sel_stat_t;
endpackage

// *** rtl/sync_sel_regs.svh ***
// register map, field positions, reset values and timing counts
`ifndef SYNC_SEL_REGS_SVH
`define SYNC_SEL_REGS_SVH
`define REG_CTRL      32'h0000_0000
`define REG_FREQ      32'h0000_0004
`define REG_STAT      32'h0000_0008
`define CTRL_EN_BIT   0
`define CTRL_MODE_LSB 1
`define CTRL_OD_BIT   3
`define CTRL_RST      4'h0
`define FREQ_RST      16'h0190
`define FREQ_QMASK    16'hfff8
`define OSC_KHZ       16'h8235
`define DET_WIN_CYC   16'h0100
`define DET_MIN_EDGES 8'h04
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// *** test/sync_clk_src_model.sv ***
// behavioural external clock source sitting on the shared sync line
`timescale 1ns/1ps
`default_nettype none
module sync_clk_src_model #(
  parameter int HALF_NS      = 60,
  parameter int SLOW_HALF_NS = 400
) (
  input  wire logic i_run,
  input  wire logic i_slow,
  output logic      o_drive,
  output logic      o_level
);
  // fixed period while on, so it is stable before any enable
  // when stopped the source lets go and the pull-up sets the line
  initial begin
    o_drive = 1'b0;
    o_level = 1'b1;
    forever begin
      if (i_run) begin
        o_drive = 1'b1;
        o_level = 1'b1;
        #(i_slow ? SLOW_HALF_NS : HALF_NS);
        o_level = 1'b0;
        #(i_slow ? SLOW_HALF_NS : HALF_NS);
      end else begin
        o_drive = 1'b0;
        o_level = 1'b1;
        @(posedge i_run);
      end
    end
  end
endmodule
`default_nettype wire

// *** test/tb_sync_clock_source_select.sv ***
// self-checking bench for the switching clock source select block
`timescale 1ns/1ps
`default_nettype none
`include "sync_sel_regs.svh"
module tb_sync_clock_source_select
  import sync_sel_pkg::*;
;
  typedef struct packed {
    sync_mode_t mode;
    logic       od;
    logic [1:0] ext;
    logic       sw;
    logic       lk;
    logic       oe;
    logic       hi;
  } row_t;
  logic        clk, rst, osc, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sync_out, sync_oe, sw_clk, sw_tick, switching;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] st;
  logic        ext_run, ext_slow, ext_drv, ext_lvl, clr, saw_oe, saw_hi, saw_tick, saw_clk;
  wire         sync_line;
  int          err_total, checks_done;
  row_t        rows [8];

  sync_clock_source_select #(.WIN_CYC(16'h0020)) dut (
    .i_ref_clk(clk), .i_reset(rst), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_osc_clk(osc),
    .i_sync_in(sync_line), .o_sync_out(sync_out), .o_sync_oe(sync_oe), .o_sw_clk(sw_clk),
    .o_sw_tick(sw_tick), .o_switching(switching));

  sync_clk_src_model ext (.i_run(ext_run), .i_slow(ext_slow), .o_drive(ext_drv), .o_level(ext_lvl));

  // shared line: device drive wins, else the source, else the pull-up
  assign sync_line = sync_oe ? sync_out : (ext_drv ? ext_lvl : 1'b1);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // oscillator phase is offset so the two domains never line up
  initial begin
    osc = 1'b0;
    #7;
    forever #15 osc = ~osc;
  end

  // sticky flags on the oscillator side, since tick lasts one osc cycle
  always @(posedge osc) begin
    if (clr) begin
      saw_oe <= 1'b0;
      saw_hi <= 1'b0;
      saw_tick <= 1'b0;
      saw_clk <= 1'b0;
    end else begin
      if (sw_clk) saw_clk <= 1'b1;
      if (sync_oe) saw_oe <= 1'b1;
      if (sync_oe && sync_out) saw_hi <= 1'b1;
      if (sw_tick) saw_tick <= 1'b1;
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic timeout;
    err_total++;
    $display("mismatch at %0t: wait ran out", $time);
    conclude();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 100) timeout();
  endtask

  task automatic rd(input logic [31:0] a);
    int n;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    st = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 100) timeout();
  endtask

  // mode is set with enable low, then enable alone is raised
  task automatic start(input sync_mode_t m, input logic od);
    wr(`REG_CTRL, {28'h0, od, m, 1'b0});
    clr <= 1'b1;
    idle(4);
    clr <= 1'b0;
    wr(`REG_CTRL, {28'h0, od, m, 1'b1});
  endtask

  task automatic run_case(input row_t r);
    ext_run <= (r.ext != 2'h0);
    ext_slow <= (r.ext == 2'h2);
    start(r.mode, r.od);
    idle(150);
    rd(`REG_STAT);
    chk(32'(st[3:2]), 32'({r.sw, r.lk}));
    chk(32'(switching), 32'(r.sw));
    chk(32'(saw_tick), 32'(r.sw));
    chk(32'(saw_clk), 32'(r.sw));
    chk(32'({saw_oe, saw_hi}), 32'({r.oe, r.hi}));
    wr(`REG_CTRL, 32'h0);
    idle(20);
  endtask

  initial begin
    // mode, open drain, source (0 off 1 on 2 slow), switching, locked, oe seen, high driven
    rows[0] = '{MODE_DISABLED, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0};
    rows[1] = '{MODE_AUTO, 1'b0, 2'h1, 1'b1, 1'b1, 1'b0, 1'b0};
    rows[2] = '{MODE_AUTO, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0};
    rows[3] = '{MODE_AUTO, 1'b0, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0};
    rows[4] = '{MODE_INPUT, 1'b0, 2'h1, 1'b1, 1'b1, 1'b0, 1'b0};
    rows[5] = '{MODE_INPUT, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0};
    // only this device drives the line in output mode, source kept off
    rows[6] = '{MODE_OUTPUT, 1'b0, 2'h0, 1'b1, 1'b0, 1'b1, 1'b1};
    rows[7] = '{MODE_OUTPUT, 1'b1, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0};
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, ext_run, ext_slow, clr} = 8'h00;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    wstrb = 4'hf;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`REG_CTRL);
    chk(st, 32'h0);
    rd(`REG_FREQ);
    chk(st, 32'h0000_0190);
    $display("reset values done");
    // the source runs at four osc cycles, so the setting is matched to it
    wr(`REG_FREQ, 32'h0000_208f);
    rd(`REG_FREQ);
    chk(st, 32'h0000_2088);
    // a write to the upper byte alone keeps the lower byte
    wstrb <= 4'h2;
    wr(`REG_FREQ, 32'h0000_55ff);
    wstrb <= 4'hf;
    rd(`REG_FREQ);
    chk(st, 32'h0000_5588);
    wr(`REG_FREQ, 32'h0000_208f);
    wr(32'h0000_000c, 32'h1);
    chk(32'(resp), 32'(`RESP_SLVERR));
    rd(32'h0000_000c);
    chk({st[29:0], resp}, 32'(`RESP_SLVERR));
    $display("register access done");
    for (int i = 0; i < 8; i++) begin
      run_case(rows[i]);
      $display("case %0d done", i);
    end
    // auto: lock, lose the source mid-run, then lock again at the next enable
    ext_run <= 1'b1;
    ext_slow <= 1'b0;
    start(MODE_AUTO, 1'b0);
    idle(150);
    ext_run <= 1'b0;
    idle(150);
    rd(`REG_STAT);
    chk(32'(st[3:2]), 32'h2);
    chk(32'(switching), 32'h1);
    wr(`REG_CTRL, 32'h0);
    ext_run <= 1'b1;
    idle(20);
    start(MODE_AUTO, 1'b0);
    idle(150);
    rd(`REG_STAT);
    chk(32'(st[3:2]), 32'h3);
    wr(`REG_CTRL, 32'h0);
    idle(20);
    $display("auto loss done");
    // input: no free-run after the source goes away
    start(MODE_INPUT, 1'b0);
    idle(150);
    rd(`REG_STAT);
    chk(32'(st[3:2]), 32'h3);
    ext_run <= 1'b0;
    idle(150);
    chk(32'(switching), 32'h0);
    wr(`REG_CTRL, 32'h0);
    $display("input loss done");
    // reset in mid-run: switching and the pin drive stop, registers return
    start(MODE_OUTPUT, 1'b0);
    idle(100);
    chk(32'({switching, sync_oe}), 32'h3);
    rst <= 1'b1;
    idle(4);
    chk(32'({switching, sync_oe}), 32'h0);
    rst <= 1'b0;
    rd(`REG_CTRL);
    chk(st, 32'h0);
    rd(`REG_FREQ);
    chk(st, 32'h0000_0190);
    $display("mid-run reset done");
    conclude();
  end
endmodule
`default_nettype wire
